// File: sdrcb_pkg.sv
`default_nettype none
package sdrcb_pkg;
   // ======================================================
   // Clock and timing.
   localparam int CLK_PERIOD_NS = 10;
   localparam int ROW_PRECHARGE_TIME_NS = 20;
   localparam int SELF_REFRESH_EXIT_DELAY_NS = 70;
   localparam int REFRESH_INTERVAL_NS = 7810;
   localparam int REFRESH_COUNT = 8192;
   localparam int REFRESH_PERIOD_MS = 64;
   // ======================================================
   // Widths of the by-16 organisation.
   localparam int ROW_W = 13;
   localparam int COL_W = 9;
   localparam int DQ_W = 16;
   localparam int DQM_W = 2;
   localparam int MODE_W = 12;
   localparam int CNT_W = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_W = 2 + ROW_W + COL_W + DQM_W + DQ_W;
   // ======================================================
   // Address bit positions.
   localparam int AUTO_PRECHARGE_BIT = 10;
   // ======================================================
   // Mode register fields and reset value.
   localparam int MR_BL_LSB = 0;
   localparam int MR_BT_BIT = 3;
   localparam int MR_CL_LSB = 4;
   localparam logic [2:0] MR_BL_FULL = 3'h7;
   localparam logic [2:0] MR_CL_THREE = 3'h3;
   localparam logic [MODE_W-1:0] MODE_RESET = 12'h020;
   // ======================================================
   // Decoded commands and self refresh states.
   typedef enum logic [3:0] {
      CMD_INHIBIT, CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE,
      CMD_TERMINATE, CMD_PRECHARGE, CMD_REFRESH, CMD_MODE
   } sdrcb_cmd_t;
   typedef enum logic [1:0] {
      SR_NORMAL, SR_SELF, SR_EXIT
   } sdrcb_sr_t;
endpackage : sdrcb_pkg
`default_nettype wire

// File: sdrcb_top.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Write data buffer.
module sdrcb_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;
   logic [AW:0] next_count;

   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr];

   always_comb begin
      next_count = count;
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         count <= next_count;
         in_ready <= (next_count != (AW+1)'(DEPTH));
         out_valid <= (next_count != '0);
      end
   end
endmodule : sdrcb_fifo

// Summary of operation
// - NO_OPERATION_CMD or deselect starts nothing, work continues.
// - Mode load uses address bits 0-11 only.
// - Activate opens row in selected bank.
// - Read starts burst from column bits 0-8.
// - Write starts burst, same column bits.
// - Bit ten selects auto precharge per command.
// - No auto precharge in full-page bursts.
// - Read mask gates outputs two clocks later.
// - Write mask in data cycle blocks byte.
// - Precharge one bank, or all with bit ten.
// - Precharged bank idle, ready after precharge time.
// - Terminate cuts latest burst, row stays open.
// - Refresh needs idle banks; address inputs ignored.
// - Refresh code with gate low enters self refresh.
// - Commands decoded from select and three strobes.
// - Read data after latency two or three.
module sdrcb_top #(
   parameter int ROW_PRECHARGE_TIME_NS = sdrcb_pkg::ROW_PRECHARGE_TIME_NS,
   parameter int SELF_REFRESH_EXIT_DELAY_NS = sdrcb_pkg::SELF_REFRESH_EXIT_DELAY_NS,
   parameter int REFRESH_INTERVAL_NS = sdrcb_pkg::REFRESH_INTERVAL_NS
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic bank_select_lo,
   input wire logic bank_select_hi,
   input wire logic [sdrcb_pkg::ROW_W-1:0] addr,
   input wire logic [sdrcb_pkg::DQM_W-1:0] dqm,
   input wire logic [sdrcb_pkg::DQ_W-1:0] dq_in,
   output logic [sdrcb_pkg::DQ_W-1:0] dq_out,
   output logic [sdrcb_pkg::DQ_W-1:0] dq_oe_n,
   output logic arr_rd_en,
   output logic [1:0] arr_rd_bank,
   output logic [sdrcb_pkg::ROW_W-1:0] arr_rd_row,
   output logic [sdrcb_pkg::COL_W-1:0] arr_rd_col,
   input wire logic [sdrcb_pkg::DQ_W-1:0] arr_rd_data,
   output logic arr_wr_valid,
   input wire logic arr_wr_ready,
   output logic [sdrcb_pkg::FIFO_W-1:0] arr_wr_word,
   output logic write_ready,
   output logic [sdrcb_pkg::MODE_W-1:0] mode_reg,
   output logic [3:0] bank_open,
   output logic [3:0] bank_ready,
   output logic [sdrcb_pkg::ROW_W-1:0] refresh_row,
   output logic self_refresh_active
);
   import sdrcb_pkg::*;

   localparam int RP_CYC_I = (ROW_PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int XSR_CYC_I = (SELF_REFRESH_EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REFI_CYC_I = REFRESH_INTERVAL_NS / CLK_PERIOD_NS;
   localparam logic [CNT_W-1:0] RP_CYC = CNT_W'(RP_CYC_I < 1 ? 1 : RP_CYC_I);
   localparam logic [CNT_W-1:0] XSR_CYC = CNT_W'(XSR_CYC_I < 2 ? 2 : XSR_CYC_I);
   localparam logic [12:0] REFI_CYC = 13'(REFI_CYC_I < 1 ? 1 : REFI_CYC_I);

   // ======================================================
   // Helpers.
   function automatic sdrcb_cmd_t decode(input logic c, input logic r,
                                         input logic a, input logic w);
      if (c) begin
         return CMD_INHIBIT;
      end
      case ({r, a, w})
         3'h7: return CMD_NOP;
         3'h3: return CMD_ACTIVE;
         3'h5: return CMD_READ;
         3'h4: return CMD_WRITE;
         3'h6: return CMD_TERMINATE;
         3'h2: return CMD_PRECHARGE;
         3'h1: return CMD_REFRESH;
         3'h0: return CMD_MODE;
         default: return CMD_NOP;
      endcase
   endfunction : decode

   function automatic logic [COL_W-1:0] len_mask(input logic [2:0] bl);
      case (bl)
         3'h0: return 9'h000;
         3'h1: return 9'h001;
         3'h2: return 9'h003;
         3'h3: return 9'h007;
         MR_BL_FULL: return 9'h1ff;
         default: return 9'h000;
      endcase
   endfunction : len_mask

   // ======================================================
   // Command decode.
   sdrcb_sr_t sr_state;
   sdrcb_cmd_t cmd;
   logic [1:0] bsel;
   logic [COL_W-1:0] bmask;
   logic full_page;
   logic interleave;
   logic cl_three;
   logic sr_entry;

   always_comb begin
      cmd = decode(cs_n, ras_n, cas_n, we_n);
      // Only the gate is watched while self refresh runs.
      if (sr_state != SR_NORMAL) begin
         cmd = CMD_NOP;
      end else if (!cke && cmd != CMD_REFRESH) begin
         cmd = CMD_NOP;
      end
   end

   assign sr_entry = (cmd == CMD_REFRESH) && !cke;
   assign bsel = {bank_select_hi, bank_select_lo};
   assign full_page = (mode_reg[MR_BL_LSB +: 3] == MR_BL_FULL);
   assign bmask = len_mask(mode_reg[MR_BL_LSB +: 3]);
   assign interleave = mode_reg[MR_BT_BIT] && !full_page;
   assign cl_three = (mode_reg[MR_CL_LSB +: 3] == MR_CL_THREE);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mode_reg <= MODE_RESET;
      end else if (cmd == CMD_MODE) begin
         mode_reg <= addr[MODE_W-1:0];
      end
   end

   // ======================================================
   // Burst engine.
   logic bst_active;
   logic bst_read;
   logic bst_ap;
   logic [1:0] bst_bank;
   logic [COL_W-1:0] bst_start;
   logic [COL_W-1:0] bst_cnt;
   logic beat_go;
   logic beat_read;
   logic beat_last;
   logic beat_ap;
   logic [1:0] beat_bank;
   logic [COL_W-1:0] beat_col;
   logic [COL_W-1:0] beat_cnt;
   logic [COL_W-1:0] beat_start;
   logic [COL_W-1:0] beat_off;
   logic ap_fire;
   logic new_burst;
   logic cut_burst;
   logic [ROW_W-1:0] open_row [4];

   assign new_burst = (cmd == CMD_READ) || (cmd == CMD_WRITE);
   assign cut_burst = (cmd == CMD_TERMINATE)
      || (cmd == CMD_PRECHARGE && (addr[AUTO_PRECHARGE_BIT] || bsel == bst_bank));

   always_comb begin
      beat_go = 1'b0;
      beat_read = bst_read;
      beat_bank = bst_bank;
      beat_start = bst_start;
      beat_cnt = bst_cnt;
      beat_ap = bst_ap;
      if (new_burst) begin
         beat_go = 1'b1;
         beat_read = (cmd == CMD_READ);
         beat_bank = bsel;
         beat_start = addr[COL_W-1:0];
         beat_cnt = '0;
         beat_ap = addr[AUTO_PRECHARGE_BIT] && !full_page;
      end else if (bst_active && !cut_burst) begin
         beat_go = 1'b1;
      end
      beat_off = interleave ? (beat_start ^ beat_cnt) : (beat_start + beat_cnt);
      beat_col = (beat_start & ~bmask) | (beat_off & bmask);
      beat_last = !full_page && (beat_cnt == bmask);
   end

   assign ap_fire = beat_go && beat_last && beat_ap;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bst_active <= 1'b0;
         bst_read <= 1'b0;
         bst_ap <= 1'b0;
         bst_bank <= '0;
         bst_start <= '0;
         bst_cnt <= '0;
      end else if (new_burst) begin
         bst_active <= !beat_last;
         bst_read <= beat_read;
         bst_ap <= beat_ap;
         bst_bank <= beat_bank;
         bst_start <= beat_start;
         bst_cnt <= 9'h001;
      end else if (cut_burst) begin
         bst_active <= 1'b0;
      end else if (beat_go) begin
         bst_cnt <= bst_cnt + 1'b1;
         bst_active <= !beat_last;
      end
   end

   // ======================================================
   // Bank state.
   logic [CNT_W-1:0] rp_cnt [4];

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bank_open <= '0;
         bank_ready <= '1;
         for (int i = 0; i < 4; i++) begin
            rp_cnt[i] <= '0;
            open_row[i] <= '0;
         end
      end else begin
         for (int i = 0; i < 4; i++) begin
            if ((cmd == CMD_PRECHARGE && (addr[AUTO_PRECHARGE_BIT] || bsel == 2'(i)))
                || (ap_fire && beat_bank == 2'(i))) begin
               bank_open[i] <= 1'b0;
               rp_cnt[i] <= RP_CYC;
               bank_ready[i] <= 1'b0;
            end else if (cmd == CMD_ACTIVE && bsel == 2'(i)) begin
               bank_open[i] <= 1'b1;
               open_row[i] <= addr;
               bank_ready[i] <= 1'b0;
            end else if (rp_cnt[i] != '0) begin
               rp_cnt[i] <= rp_cnt[i] - 1'b1;
               bank_ready[i] <= (rp_cnt[i] == 8'h01);
            end
         end
      end
   end

   // ======================================================
   // Read path.
   logic [DQ_W-1:0] rd_stage_data;
   logic rd_stage_valid;
   logic [DQM_W-1:0] dqm_d1;
   logic rd_sel_valid;

   assign rd_sel_valid = cl_three ? rd_stage_valid : arr_rd_en;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         arr_rd_en <= 1'b0;
         arr_rd_bank <= '0;
         arr_rd_row <= '0;
         arr_rd_col <= '0;
      end else begin
         arr_rd_en <= beat_go && beat_read;
         arr_rd_bank <= beat_bank;
         arr_rd_row <= open_row[beat_bank];
         arr_rd_col <= beat_col;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rd_stage_data <= '0;
         rd_stage_valid <= 1'b0;
         dqm_d1 <= '0;
         dq_out <= '0;
         dq_oe_n <= '1;
      end else begin
         rd_stage_data <= arr_rd_data;
         rd_stage_valid <= arr_rd_en;
         dqm_d1 <= dqm;
         dq_out <= cl_three ? rd_stage_data : arr_rd_data;
         for (int b = 0; b < DQM_W; b++) begin
            dq_oe_n[b*8 +: 8] <= {8{!(rd_sel_valid && !dqm_d1[b])}};
         end
      end
   end

   // ======================================================
   // Write path.
   logic fifo_in_valid;
   logic [FIFO_W-1:0] fifo_in_data;

   assign fifo_in_valid = beat_go && !beat_read;
   assign fifo_in_data = {beat_bank, open_row[beat_bank], beat_col, dqm, dq_in};

   sdrcb_fifo #(
      .WIDTH(FIFO_W),
      .DEPTH(FIFO_DEPTH)
   ) u_wr_fifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_valid(fifo_in_valid),
      .in_ready(write_ready),
      .in_data(fifo_in_data),
      .out_valid(arr_wr_valid),
      .out_ready(arr_wr_ready),
      .out_data(arr_wr_word)
   );

   // ======================================================
   // Refresh and self refresh.
   logic [CNT_W-1:0] xsr_cnt;
   logic [12:0] refi_cnt;
   logic sr_tick;

   assign sr_tick = (sr_state == SR_SELF) && (refi_cnt == '0);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sr_state <= SR_NORMAL;
         xsr_cnt <= '0;
         self_refresh_active <= 1'b0;
      end else begin
         case (sr_state)
            SR_NORMAL: begin
               if (sr_entry) begin
                  sr_state <= SR_SELF;
                  self_refresh_active <= 1'b1;
               end
            end
            SR_SELF: begin
               if (cke) begin
                  sr_state <= SR_EXIT;
                  xsr_cnt <= XSR_CYC - 1'b1;
               end
            end
            SR_EXIT: begin
               if (xsr_cnt == '0) begin
                  sr_state <= SR_NORMAL;
                  self_refresh_active <= 1'b0;
               end else begin
                  xsr_cnt <= xsr_cnt - 1'b1;
               end
            end
            default: begin
               sr_state <= SR_NORMAL;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst || sr_state != SR_SELF) begin
         refi_cnt <= REFI_CYC - 1'b1;
      end else if (sr_tick) begin
         refi_cnt <= REFI_CYC - 1'b1;
      end else begin
         refi_cnt <= refi_cnt - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         refresh_row <= '0;
      end else if ((cmd == CMD_REFRESH && cke) || sr_tick) begin
         refresh_row <= refresh_row + 1'b1;
      end
   end
endmodule : sdrcb_top

`default_nettype wire

// File: sdrcb_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ======================================================
// Memory controller model driving the command and data pins.
module sdrcb_ctrl_model (
   input wire logic clk,
   output logic cke,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic bank_select_lo,
   output logic bank_select_hi,
   output logic [sdrcb_pkg::ROW_W-1:0] addr,
   output logic [sdrcb_pkg::DQM_W-1:0] dqm,
   output logic [sdrcb_pkg::DQ_W-1:0] dq_in
);
   import sdrcb_pkg::*;
   initial begin
      {cke, cs_n, ras_n, cas_n, we_n} = 5'h1f;
      {bank_select_hi, bank_select_lo} = 2'h0;
      addr = '0;
      dqm = '0;
      dq_in = '0;
   end
   // Pins change after the falling edge and hold across the next rising edge.
   task automatic issue(input logic [4:0] k, input logic [1:0] kb, input logic [ROW_W-1:0] ka,
                        input logic [DQM_W-1:0] km, input logic [DQ_W-1:0] kd);
      @(negedge clk);
      {cke, cs_n, ras_n, cas_n, we_n} = k;
      {bank_select_hi, bank_select_lo} = kb;
      addr = (k[3:0] == 4'h0) ? {1'b0, ka[ROW_W-2:0]} : ka;
      dqm = km;
      dq_in = kd;
   endtask : issue
endmodule : sdrcb_ctrl_model
`default_nettype wire

// File: sdrcb_chk_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sdrcb_chk (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic bank_select_lo,
   input wire logic bank_select_hi,
   input wire logic [sdrcb_pkg::ROW_W-1:0] addr,
   input wire logic [sdrcb_pkg::DQM_W-1:0] dqm,
   input wire logic [sdrcb_pkg::DQ_W-1:0] dq_out,
   input wire logic [sdrcb_pkg::DQ_W-1:0] dq_oe_n,
   input wire logic [sdrcb_pkg::DQ_W-1:0] arr_rd_data,
   input wire logic [sdrcb_pkg::MODE_W-1:0] mode_reg,
   input wire logic [3:0] bank_open,
   input wire logic [3:0] bank_ready,
   input wire logic [sdrcb_pkg::ROW_W-1:0] refresh_row,
   input wire logic self_refresh_active
);
   import sdrcb_pkg::*;
   logic [3:0] code;
   logic [1:0] bank;
   logic [1:0] pb;
   logic [11:0] op;
   logic live;
   assign code = {cs_n, ras_n, cas_n, we_n};
   assign bank = {bank_select_hi, bank_select_lo};
   assign op = addr[11:0];
   assign live = cke && !self_refresh_active;
   // Remembers the bank of the last single-bank precharge.
   always_ff @(posedge clk) begin
      if (code == 4'h2 && !addr[AUTO_PRECHARGE_BIT]) begin
         pb <= bank;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_rp_wait;
      !bank_ready[pb] ##[1:2] bank_ready[pb];
   endsequence
   sequence s_read_cl2;
      code == 4'h5 && live && dqm == 2'h0 && mode_reg[6:4] != 3'h3;
   endsequence
   a_nop_holds_state: assert property ((cs_n || code == 4'h7) && live |=>
      $stable(mode_reg) && $stable(refresh_row)) else $error("idle command changed state");
   a_mode_load_op: assert property (code == 4'h0 && live |=> mode_reg == $past(op))
      else $error("mode load wrong");
   a_act_opens_bank: assert property (code == 4'h3 && live |=>
      bank_open[$past(bank)] && !bank_ready[$past(bank)]) else $error("activate wrong");
   a_pre_one_bank: assert property (code == 4'h2 && live && !addr[10] |=> !bank_open[pb])
      else $error("precharge left bank open");
   a_pre_all_banks: assert property (code == 4'h2 && live && addr[10] |=> bank_open == 4'h0)
      else $error("precharge all left a bank open");
   a_pre_ready_wait: assert property (code == 4'h2 && live && !addr[10] && bank_open[bank] |=>
      s_rp_wait) else $error("bank ready timing wrong");
   a_mask_read_hiz: assert property (dqm[0] |-> ##2 dq_oe_n[7:0] == 8'hff)
      else $error("masked byte driven");
   a_read_data_cl2: assert property (s_read_cl2 |-> ##2
      dq_oe_n == 16'h0 && dq_out == $past(arr_rd_data)) else $error("read data wrong");
   a_refresh_row_step: assert property (code == 4'h1 && live |=>
      refresh_row == $past(refresh_row) + 13'h1) else $error("refresh row not stepped");
   a_self_entry_now: assert property (code == 4'h1 && !cke && !self_refresh_active |=>
      self_refresh_active) else $error("self refresh not entered");
   a_self_ignores_cmds: assert property (self_refresh_active |=> $stable(bank_open))
      else $error("command taken in self refresh");
endmodule : sdrcb_chk
bind sdrcb_top sdrcb_chk sdrcb_chk_inst (.clk(clk), .sys_rst(sys_rst), .cke(cke), .cs_n(cs_n),
   .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_select_lo(bank_select_lo),
   .bank_select_hi(bank_select_hi), .addr(addr), .dqm(dqm), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
   .arr_rd_data(arr_rd_data), .mode_reg(mode_reg), .bank_open(bank_open),
   .bank_ready(bank_ready), .refresh_row(refresh_row),
   .self_refresh_active(self_refresh_active));
`default_nettype wire

// File: sdram_command_bank_protocol_test.sv
`timescale 1ns/1ps
`default_nettype none
module sdram_command_bank_protocol_test;
   import sdrcb_pkg::*;
   localparam logic [4:0] no_operation_cmd = 5'h17;
   localparam logic [4:0] c_act = 5'h13;
   localparam logic [4:0] c_rd = 5'h15;
   localparam logic [4:0] c_wr = 5'h14;
   localparam logic [4:0] c_term = 5'h16;
   localparam logic [4:0] c_pre = 5'h12;
   localparam logic [4:0] c_ref = 5'h11;
   localparam logic [4:0] c_mode = 5'h10;
   logic clk, sys_rst, cke, cs_n, ras_n, cas_n, we_n, bank_select_lo, bank_select_hi, ap;
   logic arr_rd_en, arr_wr_valid, arr_wr_ready, write_ready, self_refresh_active;
   logic [ROW_W-1:0] addr, arr_rd_row, refresh_row, r, mw;
   logic [DQ_W-1:0] dq_in, dq_out, dq_oe_n, arr_rd_data;
   logic [1:0] dqm, arr_rd_bank, b, m;
   logic [COL_W-1:0] arr_rd_col, c;
   logic [FIFO_W-1:0] arr_wr_word;
   logic [MODE_W-1:0] mode_reg;
   logic [3:0] bank_open, bank_ready;
   int fail_count, num_checks, seed, i, n, cl;
   // ======================================================
   // Array model and instances.
   function automatic logic [15:0] exp_data(input logic [1:0] eb, input logic [12:0] er,
                                            input logic [8:0] ec);
      return {er[4:0], eb, ec};
   endfunction : exp_data
   assign arr_rd_data = exp_data(arr_rd_bank, arr_rd_row, arr_rd_col);
   sdrcb_top #(.REFRESH_INTERVAL_NS(100)) sdrcb_top_inst (.clk(clk), .sys_rst(sys_rst),
      .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
      .bank_select_lo(bank_select_lo), .bank_select_hi(bank_select_hi), .addr(addr),
      .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .arr_rd_en(arr_rd_en),
      .arr_rd_bank(arr_rd_bank), .arr_rd_row(arr_rd_row), .arr_rd_col(arr_rd_col),
      .arr_rd_data(arr_rd_data), .arr_wr_valid(arr_wr_valid), .arr_wr_ready(arr_wr_ready),
      .arr_wr_word(arr_wr_word), .write_ready(write_ready), .mode_reg(mode_reg),
      .bank_open(bank_open), .bank_ready(bank_ready), .refresh_row(refresh_row),
      .self_refresh_active(self_refresh_active));
   sdrcb_ctrl_model sdrcb_ctrl_model_inst (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .bank_select_lo(bank_select_lo),
      .bank_select_hi(bank_select_hi), .addr(addr), .dqm(dqm), .dq_in(dq_in));
   // ======================================================
   // Shared tasks.
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] want);
      num_checks++;
      if (seen !== want) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, want, seen);
      end
   endtask : check
   task automatic print_verdict;
      if (fail_count == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : print_verdict
   task automatic cmd(input logic [4:0] k, input logic [1:0] kb, input logic [12:0] ka);
      sdrcb_ctrl_model_inst.issue(k, kb, ka, 2'h0, ~dq_in);
   endtask : cmd
   task automatic idle(input int k, input logic [1:0] km);
      repeat (k) sdrcb_ctrl_model_inst.issue(no_operation_cmd, 2'h0, 13'h0, km, ~dq_in);
   endtask : idle
   task automatic read_burst;
      logic [15:0] hz;
      hz = {{8{m[1]}}, {8{m[0]}}};
      sdrcb_ctrl_model_inst.issue(c_rd, b, {2'h0, ap, 1'b0, c}, m, 16'h0);
      idle(cl, m);
      check("dq_oe_n", dq_oe_n, hz);
      check("beat0", dq_out & ~hz, exp_data(b, r, c) & ~hz);
      idle(1, m);
      check("beat1", dq_out & ~hz, exp_data(b, r, c ^ 9'h1) & ~hz);
      idle(1, m);
      check("dq_oe_n end", dq_oe_n, 16'hffff);
   endtask : read_burst
   // ======================================================
   // Stimulus.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #500000;
      fail_count++;
      print_verdict;
   end
   initial begin
      seed = 7532;
      fail_count = 0;
      num_checks = 0;
      sys_rst = 1'b1;
      arr_wr_ready = 1'b0;
      repeat (8) @(negedge clk);
      sys_rst = 1'b0;
      check("bank_ready", bank_ready, 4'hf);
      check("mode_reg", mode_reg, MODE_RESET);
      check("write_ready", write_ready, 1'b1);
      for (i = 0; i < 8; i++) begin
         cl = 2 + i % 2;
         b = 2'($random(seed));
         r = 13'($random(seed));
         c = 9'($random(seed));
         ap = 1'($random(seed));
         m = (i < 4) ? 2'h0 : 2'($random(seed));
         mw = {6'h0, ((cl == 3) ? 3'h3 : 3'h2), i[2], 3'h1};
         cmd(c_mode, 2'h0, mw);
         idle(2, 2'h0);
         check("mode_reg", mode_reg, mw[MODE_W-1:0]);
         cmd(c_act, b, r);
         idle(2, 2'h0);
         check("open", bank_open[b], 1'b1);
         read_burst();
         check("open", bank_open[b], !ap);
         if (!ap) cmd(c_pre, b, 13'h0);
         idle(3, 2'h0);
         check("open", bank_open[b], 1'b0);
         check("ready", bank_ready[b], 1'b1);
      end
      cmd(c_mode, 2'h0, 13'h027);
      idle(2, 2'h0);
      cmd(c_act, 2'h1, 13'h5);
      idle(2, 2'h0);
      cmd(c_rd, 2'h1, 13'h400);
      idle(8, 2'h0);
      check("dq_oe_n", dq_oe_n, 16'h0);
      check("open", bank_open[1], 1'b1);
      check("rd_en", arr_rd_en, 1'b1);
      cmd(c_term, 2'h1, 13'h0);
      idle(4, 2'h0);
      check("dq_oe_n", dq_oe_n, 16'hffff);
      check("open", bank_open[1], 1'b1);
      check("rd_en", arr_rd_en, 1'b0);
      cmd(c_act, 2'h2, 13'h9);
      idle(2, 2'h0);
      cmd(c_pre, 2'h0, 13'h400);
      idle(3, 2'h0);
      check("open", bank_open, 4'h0);
      cmd(c_mode, 2'h0, 13'h021);
      idle(2, 2'h0);
      cmd(c_act, 2'h3, 13'h1abc);
      idle(2, 2'h0);
      sdrcb_ctrl_model_inst.issue(c_wr, 2'h3, 13'h10e, 2'h2, 16'h1234);
      sdrcb_ctrl_model_inst.issue(no_operation_cmd, 2'h0, 13'h0, 2'h1, 16'hbeef);
      check("word0", arr_wr_word, {2'h3, 13'h1abc, 9'h10e, 2'h2, 16'h1234});
      idle(1, 2'h0);
      arr_wr_ready = 1'b1;
      idle(1, 2'h0);
      arr_wr_ready = 1'b0;
      check("word1", arr_wr_word, {2'h3, 13'h1abc, 9'h10f, 2'h1, 16'hbeef});
      for (i = 0; i < 15; i++) sdrcb_ctrl_model_inst.issue(c_wr, 2'h3, 13'(i), 2'h0, 16'(i));
      idle(1, 2'h0);
      check("write_ready", write_ready, 1'b0);
      n = 0;
      for (i = 0; i < 200 && arr_wr_valid === 1'b1; i++) begin
         arr_wr_ready = 1'($random(seed));
         if (arr_wr_ready) n++;
         @(negedge clk);
      end
      arr_wr_ready = 1'b0;
      check("drained", n, 16);
      check("wr_valid", arr_wr_valid, 1'b0);
      cmd(c_pre, 2'h0, 13'h400);
      idle(3, 2'h0);
      r = refresh_row;
      cmd(5'h01, 2'h0, 13'h0);
      repeat (30) cmd(5'h03, 2'h2, 13'h0);
      check("self", self_refresh_active, 1'b1);
      check("open", bank_open, 4'h0);
      check("row moved", refresh_row != r, 1'b1);
      for (i = 0; i < 20 && self_refresh_active === 1'b1; i++) idle(1, 2'h0);
      check("self", self_refresh_active, 1'b0);
      r = refresh_row;
      cmd(c_ref, 2'h0, 13'h1fff);
      idle(1, 2'h0);
      check("refresh_row", refresh_row, r + 13'h1);
      repeat (4) cmd(c_ref, 2'h0, 13'h0);
      idle(1, 2'h0);
      check("refresh_row", refresh_row, r + 13'h5);
      print_verdict;
   end
endmodule : sdram_command_bank_protocol_test
`default_nettype wire
